// ### hw/slcg_map.svh
`ifndef SLCG_MAP_SVH
`define SLCG_MAP_SVH
// bit positions inside the core control register
`define SLCG_BIT_SEL_HI   7
`define SLCG_BIT_SLP_EN   6
`define SLCG_BIT_SEL_MID  5
`define SLCG_BIT_SEL_LO   4
// reset value of the core control register
`define SLCG_CTRL_RST     8'h00
// sleep mode codes, {hi, mid, lo}
`define SLCG_MD_IDLE      3'h0
`define SLCG_MD_ADCNR     3'h1
`define SLCG_MD_PDOWN     3'h2
`define SLCG_MD_PSAVE     3'h3
`define SLCG_MD_RSV4      3'h4
`define SLCG_MD_RSV5      3'h5
`define SLCG_MD_STBY      3'h6
`define SLCG_MD_XSTBY     3'h7
// all gates open, all port enables cleared
`define SLCG_GATES_ON     5'h1F
`define SLCG_OE_OFF       32'h0000_0000
`endif

// ### hw/slcg_pkg.sv
`include "slcg_map.svh"
package slcg_pkg;
    // six legal sleep modes plus two reserved codes
    typedef enum logic [2:0] {
        SLCG_IDLE  = `SLCG_MD_IDLE,
        SLCG_ADCNR = `SLCG_MD_ADCNR,
        SLCG_PDOWN = `SLCG_MD_PDOWN,
        SLCG_PSAVE = `SLCG_MD_PSAVE,
        SLCG_RSV4  = `SLCG_MD_RSV4,
        SLCG_RSV5  = `SLCG_MD_RSV5,
        SLCG_STBY  = `SLCG_MD_STBY,
        SLCG_XSTBY = `SLCG_MD_XSTBY
    } slcg_mode_t;

    // controller state, one-hot
    typedef enum logic [1:0] {
        SLCG_RUN   = 2'b01,
        SLCG_SLEEP = 2'b10
    } slcg_state_t;

    // clock domain enables, high = domain clocked
    typedef struct packed {
        logic cpu;   // processor core
        logic io;    // synchronous peripherals and interrupt logic
        logic adc;   // converter clock
        logic asy;   // asynchronous timer
        logic osc;   // main oscillator
    } slcg_gate_t;
endpackage

// ### hw/slcg_top.sv
`timescale 1ns/1ps
`include "slcg_map.svh"
// Operation
// - six software-selected sleep modes
// - idle halts only the core clock
// - power-down stops oscillator, waits external wake
// - power-save keeps asynchronous timer clocked
// - noise-reduction keeps timer, converter and oscillator
// - standby keeps oscillator running only
// - extended standby keeps oscillator and timer
// - port pins high-impedance during any reset
// - control bits at positions seven to four
module slcg_top
    import slcg_pkg::*;
(
    input  wire logic        CLK_SYS,     // 10 MHz system clock
    input  wire logic        RST_N,       // asynchronous reset, active low
    input  wire logic        CLK_EN,      // freezes all state while low
    input  wire logic        CTRL_WR,     // write strobe for control register
    input  wire logic [7:0]  CTRL_WDATA,  // write data
    output logic      [7:0]  CTRL_RDATA,  // control register contents
    input  wire logic        SLEEP_EXEC,  // sleep instruction executes
    input  wire logic        EXT_IRQ,     // external interrupt pin, async
    input  wire logic        INT_IRQ,     // internal interrupt, same clock
    output slcg_gate_t       CLK_GATES,   // clock domain enables
    output logic             SLEEPING,    // high while asleep
    input  wire logic [31:0] GPIO_OUT_IN, // port output data from port logic
    input  wire logic [31:0] GPIO_OE_IN,  // port drive enables from port logic
    output logic      [31:0] GPIO_OUT,    // port pin output value
    output logic      [31:0] GPIO_OE      // port pin drive enable
);

    // external interrupt synchroniser
    logic       ext_meta_reg;   // first stage, read only by second
    logic       ext_sync_reg;   // second stage
    logic       ext_sync_next;

    // control register
    logic [7:0] ctrl_reg;       // core control register
    logic [7:0] ctrl_next;

    // sleep controller
    slcg_state_t state_reg;
    slcg_state_t state_next;
    slcg_mode_t  mode_reg;      // mode latched at sleep entry
    slcg_mode_t  mode_next;
    slcg_gate_t  gate_reg;      // registered clock enables
    slcg_gate_t  gate_next;

    // decoded software fields
    slcg_mode_t  sel_mode;      // mode requested by software
    logic        slp_en;        // sleep-enable bit
    logic        sel_legal;     // reserved codes never sleep
    logic        enter;         // sleep is taken this cycle
    logic        wake;          // qualifying wake event

    // synchroniser, pin comes from outside the clock domain
    always_comb
    begin
        ext_sync_next = ext_meta_reg;
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
        end
        else if (CLK_EN)
        begin
            ext_meta_reg <= EXT_IRQ;
            ext_sync_reg <= ext_sync_next;
        end
    end

    // field decode; mode select split across three bits
    always_comb
    begin
        sel_mode  = slcg_mode_t'({ctrl_reg[`SLCG_BIT_SEL_HI],
                                  ctrl_reg[`SLCG_BIT_SEL_MID],
                                  ctrl_reg[`SLCG_BIT_SEL_LO]});
        slp_en    = ctrl_reg[`SLCG_BIT_SLP_EN];
        // only the six named codes may sleep
        sel_legal = (sel_mode != SLCG_RSV4) && (sel_mode != SLCG_RSV5);
        enter     = SLEEP_EXEC && slp_en && sel_legal;
    end

    // wake sources depend on the mode held
    always_comb
    begin
        unique case (mode_reg)
            // idle and noise-reduction: internal or external interrupt wakes
            SLCG_IDLE, SLCG_ADCNR:
                wake = ext_sync_reg || INT_IRQ;
            // deep modes: only the external interrupt wakes
            default:
                wake = ext_sync_reg;
        endcase
    end

    // control register write; software keeps full byte
    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (CTRL_WR)
        begin
            ctrl_next = CTRL_WDATA;
        end
    end

    // state and mode next values
    always_comb
    begin
        state_next = state_reg;
        mode_next  = mode_reg;
        unique case (state_reg)
            SLCG_RUN:
            begin
                if (enter)
                begin
                    state_next = SLCG_SLEEP;
                    mode_next  = sel_mode;
                end
            end
            SLCG_SLEEP:
            begin
                // core is stopped, so no new instruction can arrive
                if (wake)
                begin
                    state_next = SLCG_RUN;
                end
            end
        endcase
    end

    // gate pattern follows next state so gates align with state_reg
    always_comb
    begin
        gate_next = `SLCG_GATES_ON;
        if (state_next == SLCG_SLEEP)
        begin
            unique case (mode_next)
                SLCG_IDLE:
                    gate_next.cpu = 1'b0;
                SLCG_ADCNR:
                begin
                    gate_next.cpu = 1'b0;
                    gate_next.io  = 1'b0;
                end
                SLCG_PDOWN:
                begin
                    // registers hold their contents with clocks off
                    gate_next = '0;
                end
                SLCG_PSAVE:
                begin
                    gate_next     = '0;
                    gate_next.asy = 1'b1;
                end
                SLCG_STBY:
                begin
                    // oscillator kept for a fast start-up
                    gate_next     = '0;
                    gate_next.osc = 1'b1;
                end
                SLCG_XSTBY:
                begin
                    gate_next     = '0;
                    gate_next.osc = 1'b1;
                    gate_next.asy = 1'b1;
                end
                default:
                    gate_next = `SLCG_GATES_ON;
            endcase
        end
    end

    // controller registers
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ctrl_reg  <= `SLCG_CTRL_RST;
            state_reg <= SLCG_RUN;
            mode_reg  <= SLCG_IDLE;
            gate_reg  <= `SLCG_GATES_ON;
        end
        else if (CLK_EN)
        begin
            ctrl_reg  <= ctrl_next;
            state_reg <= state_next;
            mode_reg  <= mode_next;
            gate_reg  <= gate_next;
        end
    end

    // outputs; port gating is combinational so it acts with no clock
    always_comb
    begin
        CTRL_RDATA = ctrl_reg;
        CLK_GATES  = gate_reg;
        SLEEPING   = (state_reg == SLCG_SLEEP);
        GPIO_OUT   = GPIO_OUT_IN;
        // any reset releases every pin at once
        GPIO_OE    = RST_N ? GPIO_OE_IN : `SLCG_OE_OFF;
        // the reset input itself is trusted to meet the pulse width
    end

    // checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    sequence s_enter;
        CLK_EN && (state_reg == SLCG_RUN) && enter;
    endsequence

    sequence s_asleep;
        state_reg == SLCG_SLEEP;
    endsequence

    a_mode_legal_only: assert property (s_asleep
        |-> (mode_reg != SLCG_RSV4) && (mode_reg != SLCG_RSV5))
        else $error("asleep in a reserved mode");
    a_idle_cpu_only: assert property (s_asleep and (mode_reg == SLCG_IDLE)
        |-> (CLK_GATES == 5'h0F))
        else $error("idle gating wrong");
    a_pdown_all_off: assert property (s_asleep and (mode_reg == SLCG_PDOWN)
        |-> (CLK_GATES == 5'h00))
        else $error("power-down gating wrong");
    // deep modes ignore the internal interrupt; only the pin or reset wakes
    a_deep_int_ignored: assert property (s_asleep and (CLK_EN && !ext_sync_reg
        && (mode_reg != SLCG_IDLE) && (mode_reg != SLCG_ADCNR)) |=> s_asleep)
        else $error("deep sleep left without external wake");
    a_psave_timer_on: assert property (s_asleep and (mode_reg == SLCG_PSAVE)
        |-> (CLK_GATES == 5'h02))
        else $error("power-save gating wrong");
    a_adcnr_gates: assert property (s_asleep and (mode_reg == SLCG_ADCNR)
        |-> (CLK_GATES == 5'h07))
        else $error("noise-reduction gating wrong");
    a_stby_osc_on: assert property (s_asleep and (mode_reg == SLCG_STBY)
        |-> (CLK_GATES == 5'h01))
        else $error("standby gating wrong");
    a_xstby_osc_timer: assert property (s_asleep and (mode_reg == SLCG_XSTBY)
        |-> (CLK_GATES == 5'h03))
        else $error("extended standby gating wrong");
    a_gpio_reset_hiz: assert property (@(posedge CLK_SYS) disable iff (1'b0)
        !RST_N |-> (GPIO_OE == 32'h0000_0000))
        else $error("port driven during reset");
    a_ctrl_write_bits: assert property (CLK_EN && CTRL_WR
        |=> (CTRL_RDATA == $past(CTRL_WDATA)))
        else $error("control register write lost");
    a_enter_sleep: assert property (s_enter |=> s_asleep and (!CLK_GATES.cpu
        && (mode_reg == $past(sel_mode))))
        else $error("sleep not entered");
    a_no_stray_sleep: assert property (CLK_EN && (state_reg == SLCG_RUN)
        && !(SLEEP_EXEC && slp_en) |=> (state_reg == SLCG_RUN))
        else $error("sleep without enable and instruction");
    a_wake_restores: assert property (s_asleep and (CLK_EN && ext_sync_reg)
        |=> (state_reg == SLCG_RUN) && (CLK_GATES == 5'h1F))
        else $error("external wake did not restore clocks");

endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import slcg_pkg::*;
;
    logic        clk_sys;      // 10 MHz system clock
    logic        rst_n;        // asynchronous reset, active low
    logic        clk_en;       // global clock enable
    logic        ctrl_wr;      // control write strobe
    logic [7:0]  ctrl_wdata;   // control write data
    logic [7:0]  ctrl_rdata;   // control register readback
    logic        sleep_exec;   // sleep instruction pulse
    logic        ext_irq;      // external wake line
    logic        int_irq;      // internal wake line
    slcg_gate_t  clk_gates;    // domain enables
    logic        sleeping;     // asleep flag
    logic [31:0] gpio_out_in;  // port data from port logic
    logic [31:0] gpio_oe_in;   // port enables from port logic
    logic [31:0] gpio_out;     // port data at the pins
    logic [31:0] gpio_oe;      // port enables at the pins
    logic [4:0]  pat [8];      // expected gate pattern per mode code
    int          n_errors;     // mismatches seen
    int          check_count;  // comparisons made

    slcg_top uut (.CLK_SYS(clk_sys), .RST_N(rst_n), .CLK_EN(clk_en), .CTRL_WR(ctrl_wr),
        .CTRL_WDATA(ctrl_wdata), .CTRL_RDATA(ctrl_rdata), .SLEEP_EXEC(sleep_exec),
        .EXT_IRQ(ext_irq), .INT_IRQ(int_irq), .CLK_GATES(clk_gates), .SLEEPING(sleeping),
        .GPIO_OUT_IN(gpio_out_in), .GPIO_OE_IN(gpio_oe_in), .GPIO_OUT(gpio_out),
        .GPIO_OE(gpio_oe));

    // free-running clock, 100 ns period
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // one compare, four-state exact
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // wait one rising edge; drives follow by non-blocking assignment
    task automatic cyc();
        @(posedge clk_sys);
    endtask

    // control write, readback one cycle later
    task automatic wr(input logic [7:0] d);
        cyc();
        ctrl_wr <= 1'b1;
        ctrl_wdata <= d;
        cyc();
        ctrl_wr <= 1'b0;
        #10 chk({24'h0, ctrl_rdata}, {24'h0, d});
    endtask

    // one sleep instruction pulse, outputs looked at after the taking edge
    task automatic slp();
        cyc();
        sleep_exec <= 1'b1;
        cyc();
        sleep_exec <= 1'b0;
        #10;
    endtask

    // verdict and end of run
    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // hang guard, far beyond the hundred or so cycles the tests take
    initial
    begin
        #500000;
        n_errors++;
        complete_run();
    end

    // main sequence
    initial
    begin
        pat = '{5'h0F, 5'h07, 5'h00, 5'h02, 5'h1F, 5'h1F, 5'h01, 5'h03};
        n_errors = 0;
        check_count = 0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        ctrl_wr = 1'b0;
        ctrl_wdata = 8'h00;
        sleep_exec = 1'b0;
        ext_irq = 1'b0;
        int_irq = 1'b0;
        gpio_out_in = 32'hA5C3_0F96;
        gpio_oe_in = 32'hFFFF_FFFF;
        // port enables forced off before any edge has come
        #20 chk(gpio_oe, 32'h0000_0000);
        repeat (4) cyc();
        #10 rst_n = 1'b1;
        // let the combinational pin gating settle before looking
        #1 chk(gpio_oe, 32'hFFFF_FFFF);
        chk(gpio_out, 32'hA5C3_0F96);
        chk({24'h0, ctrl_rdata}, 32'h0000_0000);
        // every mode code: entry; latching and wake path for the six legal codes
        for (int m = 0; m < 8; m++)
        begin
            wr({m[2], 1'b1, m[1], m[0], 4'hA});
            slp();
            chk({31'h0, sleeping}, {31'h0, pat[m] != 5'h1F});
            chk({27'h0, clk_gates}, {27'h0, pat[m]});
            if (pat[m] == 5'h1F)
                continue;
            // a later write must not alter the active mode
            wr(8'h00);
            chk({27'h0, clk_gates}, {27'h0, pat[m]});
            // internal wake only for the two light modes
            cyc();
            int_irq <= 1'b1;
            cyc();
            int_irq <= 1'b0;
            #10 chk({31'h0, sleeping}, {31'h0, m > 1});
            if (m < 2)
                continue;
            // external wake lands three edges after the line rises
            cyc();
            ext_irq <= 1'b1;
            repeat (2) cyc();
            #10 chk({31'h0, sleeping}, 32'h0000_0001);
            cyc();
            ext_irq <= 1'b0;
            #10 chk({31'h0, sleeping}, 32'h0000_0000);
            chk({27'h0, clk_gates}, 32'h0000_001F);
            repeat (3) cyc();
        end
        // enable bit clear: sleep instruction has no effect
        wr(8'h20);
        slp();
        chk({31'h0, sleeping}, 32'h0000_0000);
        chk({27'h0, clk_gates}, 32'h0000_001F);
        // write while frozen is dropped without notice
        cyc();
        clk_en <= 1'b0;
        ctrl_wr <= 1'b1;
        ctrl_wdata <= 8'hC3;
        cyc();
        clk_en <= 1'b1;
        ctrl_wr <= 1'b0;
        #10 chk({24'h0, ctrl_rdata}, 32'h0000_0020);
        // reset in mid-sleep, off the edge, acts at once
        wr(8'h60);
        slp();
        #17 rst_n = 1'b0;
        #1 chk(gpio_oe, 32'h0000_0000);
        chk({31'h0, sleeping}, 32'h0000_0000);
        chk({27'h0, clk_gates}, 32'h0000_001F);
        chk({24'h0, ctrl_rdata}, 32'h0000_0000);
        // held well past one edge, as the reset pin needs
        repeat (3) cyc();
        #10 rst_n = 1'b1;
        #1 chk(gpio_oe, 32'hFFFF_FFFF);
        complete_run();
    end
endmodule
